// [acc_pkg.sv]
// constants shared by the audio codec control block
package acc_pkg;
    // register indices on the control register port
    localparam logic [3:0]  ACC_OFS_CTRL_A     = 4'h7;
    localparam logic [3:0]  ACC_OFS_CTRL_B     = 4'h8;
    localparam logic [3:0]  ACC_OFS_MODE       = 4'hD;
    localparam logic [3:0]  ACC_OFS_STATUS     = 4'hE;
    // field positions
    localparam int          ACC_DIV_LSB        = 0;
    localparam int          ACC_DIV_W          = 7;
    localparam int          ACC_GAIN_LSB       = 7;
    localparam int          ACC_GAIN_W         = 5;
    localparam int          ACC_ATTEN_LSB      = 0;
    localparam int          ACC_ATTEN_W        = 5;
    localparam int          ACC_LOOP_BIT       = 12;
    localparam int          ACC_MUTE_BIT       = 13;
    localparam int          ACC_IN_EN_BIT      = 14;
    localparam int          ACC_OFFCAN_BIT     = 13;
    // reset values
    localparam logic [15:0] ACC_RST_CTRL_A     = 16'h000C;
    localparam logic [15:0] ACC_RST_CTRL_B     = 16'h0000;
    localparam logic [15:0] ACC_RST_MODE       = 16'h0000;
    // divisor lower bound and gain ceiling (31 steps of 1.5 dB = 46.5 dB)
    localparam logic [6:0]  ACC_DIV_MIN        = 7'h08;
    localparam logic [4:0]  ACC_GAIN_MAX       = 5'h1F;
    // index of the last modulator tick in a sample (64 ticks per sample)
    localparam logic [5:0]  ACC_OSR_LAST       = 6'h3F;
    localparam logic [3:0]  ACC_FULL_CODE      = 4'hF;
endpackage

// [acc_decimator.sv]
// decimation low-pass filter: sums 64 modulator ticks into one sample
`timescale 1ns/100ps
module acc_decimator (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        tick,
    input  wire logic        frame_end,
    input  wire logic [3:0]  level,
    output logic      [15:0] sample
);
    logic [9:0]  sum_reg;       // running sum over one sample period
    logic [9:0]  sum_next;
    logic [15:0] sample_reg;    // last finished sample
    logic [9:0]  level_ext;

    assign level_ext = {6'h00, level};
    // boxcar sum over the oversampling window; its nulls at multiples of
    // the sample rate reject the aliases up to 32 times that rate
    assign sum_next  = frame_end ? 10'h000 : sum_reg + level_ext;
    assign sample    = sample_reg;

    // accumulate on each tick, hand out the sum at the window end
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            sum_reg    <= 10'h000;
            sample_reg <= 16'h0000;
        end
        else if (tick)
        begin
            sum_reg <= sum_next;
            if (frame_end)
                sample_reg <= {sum_reg + level_ext, 6'h00};
        end
    end
endmodule

// [acc_top.sv]
// audio codec control: registers, sample clock from the serial bus clock, datapath
// Notes on behaviour
// - mode bit 13 enables offset cancellation
// - sample rate is 2*fclk over 64*divisor
// - odd divisor counts both clock edges
// - even divisor counts rising edges only
// - input path off floats mic ground
// - gain field sets 1.5 dB steps
// - input gain capped at 46.5 dB
// - modulator ticks at 64 times sample rate
// - decimation filter ends the input chain
// - output interpolated 64x into 4-bit DAC
// - output has attenuation and mute
// - loopback feeds output into input path
// - digital filter rejects aliases to 32 fsa
`timescale 1ns/100ps
module acc_top (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        serial_bus_clock,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_write,
    output logic      [15:0] reg_rdata,
    input  wire logic        mic_positive_input,
    input  wire logic [15:0] play_sample,
    output logic             play_ready,
    output logic      [15:0] rec_sample,
    output logic             rec_valid,
    output logic             mod_tick,
    output logic      [3:0]  dac_code,
    output logic             offset_cancel_enable,
    output logic      [4:0]  input_gain_setting,
    output logic             mic_ground_return_o,
    output logic             mic_ground_return_oe_n
);
    ////////////////////////////////////////////////////////////////////////
    // register file
    logic [15:0] ctrl_a_reg;          // divisor and input gain
    logic [15:0] ctrl_b_reg;          // attenuation, loopback, mute, input enable
    logic [15:0] mode_reg;            // offset cancellation
    logic [15:0] rdata_reg;           // registered read data
    logic [15:0] rdata_next;
    logic        wr_a;
    logic        wr_b;
    logic        wr_mode;
    logic [15:0] rec_sample_w;        // decimator output

    assign wr_a    = reg_write && (reg_addr == acc_pkg::ACC_OFS_CTRL_A);
    assign wr_b    = reg_write && (reg_addr == acc_pkg::ACC_OFS_CTRL_B);
    assign wr_mode = reg_write && (reg_addr == acc_pkg::ACC_OFS_MODE);

    // unmapped indices read as zero
    assign rdata_next =
        (reg_addr == acc_pkg::ACC_OFS_CTRL_A) ? ctrl_a_reg :
        (reg_addr == acc_pkg::ACC_OFS_CTRL_B) ? ctrl_b_reg :
        (reg_addr == acc_pkg::ACC_OFS_MODE)   ? mode_reg   :
        (reg_addr == acc_pkg::ACC_OFS_STATUS) ? rec_sample_w : 16'h0000;
    assign reg_rdata = rdata_reg;

    // register writes, one word per strobe
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_a_reg <= acc_pkg::ACC_RST_CTRL_A;
            ctrl_b_reg <= acc_pkg::ACC_RST_CTRL_B;
            mode_reg   <= acc_pkg::ACC_RST_MODE;
            rdata_reg  <= 16'h0000;
        end
        else
        begin
            if (wr_a)
                ctrl_a_reg <= reg_wdata;
            if (wr_b)
                ctrl_b_reg <= reg_wdata;
            if (wr_mode)
                mode_reg <= reg_wdata;
            rdata_reg <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // static controls to the analog side
    logic [6:0] divisor;
    logic [4:0] gain_field;
    logic [4:0] atten;
    logic       loopback;
    logic       mute;
    logic       input_en;

    assign divisor    = ctrl_a_reg[acc_pkg::ACC_DIV_LSB +: acc_pkg::ACC_DIV_W];
    assign gain_field = ctrl_a_reg[acc_pkg::ACC_GAIN_LSB +: acc_pkg::ACC_GAIN_W];
    assign atten      = ctrl_b_reg[acc_pkg::ACC_ATTEN_LSB +: acc_pkg::ACC_ATTEN_W];
    assign loopback   = ctrl_b_reg[acc_pkg::ACC_LOOP_BIT];
    assign mute       = ctrl_b_reg[acc_pkg::ACC_MUTE_BIT];
    assign input_en   = ctrl_b_reg[acc_pkg::ACC_IN_EN_BIT];

    assign offset_cancel_enable = mode_reg[acc_pkg::ACC_OFFCAN_BIT];
    // field is 5 bits, so code 31 (46.5 dB) is already the top
    assign input_gain_setting   = (gain_field > acc_pkg::ACC_GAIN_MAX) ?
                                  acc_pkg::ACC_GAIN_MAX : gain_field;
    // ground return pulled low while the path is on, floating when off
    assign mic_ground_return_o    = 1'b0;
    assign mic_ground_return_oe_n = ~input_en;

    ////////////////////////////////////////////////////////////////////////
    // serial bus clock synchroniser and edge detect
    logic [2:0] sclk_sync_reg;        // [0] meta, [1] stable, [2] previous

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            sclk_sync_reg <= 3'b000;
        else
            sclk_sync_reg <= {sclk_sync_reg[1:0], serial_bus_clock};
    end

    logic sclk_rise;
    logic sclk_fall;
    logic div_odd;
    logic edge_hit;
    assign sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
    assign sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
    assign div_odd   = divisor[0];
    // odd divisor needs half-cycle resolution, so both edges count; a skewed
    // duty cycle then jitters the modulator tick spacing
    // even divisor keeps to rising edges only
    assign edge_hit  = div_odd ? (sclk_rise | sclk_fall) : sclk_rise;

    ////////////////////////////////////////////////////////////////////////
    // sample clock generation: fsa = 2*fclk/(64*div)
    logic [6:0] tick_len;             // edges per modulator tick
    logic [6:0] edge_cnt_reg;
    logic [6:0] edge_cnt_next;
    logic [5:0] phase_reg;            // modulator tick within the sample
    logic       tick;
    logic       frame_end;

    // both edges: div edges a tick; rising only: div/2 edges a tick
    assign tick_len  = div_odd ? divisor : {1'b0, divisor[6:1]};
    assign tick      = edge_hit && (edge_cnt_reg == 7'h00);
    assign frame_end = (phase_reg == acc_pkg::ACC_OSR_LAST);
    assign edge_cnt_next = tick ? (tick_len - 7'h01) : (edge_cnt_reg - 7'h01);

    // edge counter and tick phase; a divisor write restarts the sample period
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            edge_cnt_reg <= 7'h00;
            phase_reg    <= 6'h00;
        end
        else if (wr_a)
        begin
            edge_cnt_reg <= 7'h00;
            phase_reg    <= 6'h00;
        end
        else if (edge_hit)
        begin
            edge_cnt_reg <= edge_cnt_next;
            if (tick)
                phase_reg <= phase_reg + 6'h01; // 64 ticks a sample
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output path: attenuate, mute, interpolate and noise-shape to 4 bits
    logic [15:0] play_hold_reg;       // sample being interpolated
    logic [15:0] shaped_err_reg;      // quantiser error fed back
    logic [3:0]  dac_reg;
    logic [15:0] att_shift;
    logic [15:0] att_sample;
    logic [16:0] shaper_sum;

    // 6 dB per shift plus a quarter off for the odd 3 dB step
    assign att_shift  = play_hold_reg >> atten[4:1];
    assign att_sample = mute ? 16'h0000 :
                        (atten[0] ? att_shift - {2'b00, att_shift[15:2]} : att_shift);
    // first-order shaper: top 4 bits go out, remainder carried
    assign shaper_sum = {1'b0, att_sample} + {5'h00, shaped_err_reg[11:0]};
    assign dac_code   = dac_reg;
    assign play_ready = tick && frame_end;

    // hold input sample per frame and update the DAC code each tick
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            play_hold_reg  <= 16'h0000;
            shaped_err_reg <= 16'h0000;
            dac_reg        <= 4'h0;
        end
        else if (tick)
        begin
            if (frame_end)
                play_hold_reg <= play_sample;
            // saturate so a carry does not wrap the code to zero
            dac_reg <= shaper_sum[16] ? acc_pkg::ACC_FULL_CODE : shaper_sum[15:12];
            shaped_err_reg <= {4'h0, shaper_sum[11:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // input path: modulator bit, or DAC code in loopback
    logic [1:0] mic_sync_reg;         // mic bitstream synchroniser
    logic [3:0] dec_level;
    logic       rec_valid_reg;
    logic       mod_tick_reg;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            mic_sync_reg  <= 2'b00;
            rec_valid_reg <= 1'b0;
            mod_tick_reg  <= 1'b0;
        end
        else
        begin
            mic_sync_reg  <= {mic_sync_reg[0], mic_positive_input};
            rec_valid_reg <= tick && frame_end;
            mod_tick_reg  <= tick; // modulator sampling strobe
        end
    end

    // loopback sends the shaped output straight into the decimator
    assign dec_level = loopback ? dac_reg :
                       ((mic_sync_reg[1] && input_en) ? acc_pkg::ACC_FULL_CODE : 4'h0);

    acc_decimator acc_decimator_i (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .tick      (tick),
        .frame_end (frame_end),
        .level     (dec_level),
        .sample    (rec_sample_w)
    );

    assign rec_sample = rec_sample_w;
    assign rec_valid  = rec_valid_reg;
    assign mod_tick   = mod_tick_reg;
endmodule

// [acc_top_assertions.sv]
// port-level checks for the audio codec control block
`timescale 1ns/100ps
module acc_top_assertions (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        serial_bus_clock,
    input wire logic [3:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_write,
    input wire logic [15:0] reg_rdata,
    input wire logic        mic_positive_input,
    input wire logic [15:0] play_sample,
    input wire logic        play_ready,
    input wire logic [15:0] rec_sample,
    input wire logic        rec_valid,
    input wire logic        mod_tick,
    input wire logic [3:0]  dac_code,
    input wire logic        offset_cancel_enable,
    input wire logic [4:0]  input_gain_setting,
    input wire logic        mic_ground_return_o,
    input wire logic        mic_ground_return_oe_n
);
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (rst);
    // write decodes per register
    wire wr_a = reg_write && (reg_addr == acc_pkg::ACC_OFS_CTRL_A);
    wire wr_b = reg_write && (reg_addr == acc_pkg::ACC_OFS_CTRL_B);
    wire wr_m = reg_write && (reg_addr == acc_pkg::ACC_OFS_MODE);
    ////////////////////////////////////////////////////////////////////////////////
    AST_OFFCAN: assert property (wr_m |=> offset_cancel_enable == $past(reg_wdata[13]))
        else $error("offset cancel does not follow mode write");
    AST_OFFCAN_HOLD: assert property (!wr_m |=> $stable(offset_cancel_enable))
        else $error("offset cancel changed without mode write");
    AST_GAIN: assert property (wr_a |=> input_gain_setting == $past(reg_wdata[11:7]))
        else $error("gain does not follow control A write");
    AST_GAIN_HOLD: assert property (!wr_a |=> $stable(input_gain_setting))
        else $error("gain changed without control A write");
    AST_MIC_GROUND_RETURN: assert property (wr_b |=> mic_ground_return_oe_n == !$past(reg_wdata[14]))
        else $error("mic ground enable does not follow input enable");
    AST_MIC_GROUND_RETURN_LOW: assert property (!mic_ground_return_oe_n |-> !mic_ground_return_o)
        else $error("mic ground driven high");
    AST_FRAME: assert property (play_ready |=> rec_valid && mod_tick)
        else $error("frame end without record strobe");
    AST_TICK_PULSE: assert property (mod_tick |=> !mod_tick)
        else $error("modulator tick longer than one cycle");
    AST_REC_ALIGN: assert property (rec_valid |-> rec_sample[5:0] == 6'h00)
        else $error("record sample low bits set");
    AST_RESTART: assert property (wr_a |=> !play_ready [*8])
        else $error("frame end soon after divisor reload");
endmodule

// [acc_host_clk.sv]
// host side model: drives the serial bus clock
`timescale 1ns/100ps
module acc_host_clk #(
    parameter int HALF_NS = 200 // half period, 4 ref_clk cycles
) (
    input  wire logic run,      // clock runs while high, stands low otherwise
    output logic      serial_bus_clock
);
    // equal halves so odd-divisor ticks stay evenly spaced
    initial
    begin
        serial_bus_clock = 1'b0;
        forever
        begin
            #(HALF_NS);
            serial_bus_clock = run ? ~serial_bus_clock : 1'b0;
        end
    end
endmodule

// [tb_acc_top.sv]
// self-checking bench for the audio codec control block
`timescale 1ns/100ps
module tb_acc_top;
    logic        ref_clk, rst, sbc, reg_write, mic, run, prdy, rval, tick, ocan, oe_n, mg_o;
    logic [3:0]  reg_addr, dac;
    logic [15:0] reg_wdata, rdata, rec, play;
    logic [4:0]  gain;
    int          errors, total_checks, cycles, n;
    acc_host_clk acc_host_clk_i (.run(run), .serial_bus_clock(sbc));
    acc_top acc_top_i (.ref_clk(ref_clk), .rst(rst), .serial_bus_clock(sbc),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_rdata(rdata),
        .mic_positive_input(mic), .play_sample(play), .play_ready(prdy),
        .rec_sample(rec), .rec_valid(rval), .mod_tick(tick), .dac_code(dac),
        .offset_cancel_enable(ocan), .input_gain_setting(gain),
        .mic_ground_return_o(mg_o), .mic_ground_return_oe_n(oe_n));
    always #25 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////////////////////
    // verdict, reached from the main sequence or the watchdog
    task end_sim;
        if (errors == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // watchdog: the whole run needs about 20500 cycles
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            errors++;
            end_sim();
        end
    end
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e)
        begin
            errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    // one-cycle write strobe, register updated by the next falling edge
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge ref_clk);
        reg_write = 1'b0;
    endtask
    // read data lags the index by one cycle
    task rd(input logic [3:0] a, input logic [15:0] e, input string nm);
        @(negedge ref_clk);
        reg_addr = a;
        @(negedge ref_clk);
        chk(nm, e, rdata);
    endtask
    function logic pick(input int s);
        return (s == 0) ? tick : (s == 1) ? prdy : rval;
    endfunction
    // cycles between two successive strobes of the chosen kind
    task gap(input int s, output int g);
        @(negedge ref_clk);
        while (!pick(s)) @(negedge ref_clk);
        @(negedge ref_clk);
        g = 1;
        while (!pick(s))
        begin
            g++;
            @(negedge ref_clk);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {ref_clk, reg_write, mic, run} = 4'h0;
        rst = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        // full-scale playback, taken in at every frame end
        play = 16'hFFFF;
        repeat (16) @(negedge ref_clk);
        rst = 1'b0;
        run = 1'b1;
        rd(acc_pkg::ACC_OFS_CTRL_A, acc_pkg::ACC_RST_CTRL_A, "ctrl_a");
        rd(acc_pkg::ACC_OFS_CTRL_B, 16'h0000, "ctrl_b");
        rd(acc_pkg::ACC_OFS_MODE, 16'h0000, "mode");
        chk("oe_n", 16'h0001, {15'h0000, oe_n});
        wr(acc_pkg::ACC_OFS_MODE, 16'h2000);
        chk("offcan", 16'h0001, {15'h0000, ocan});
        wr(acc_pkg::ACC_OFS_MODE, 16'hDFFF);
        chk("offcan", 16'h0000, {15'h0000, ocan});
        wr(acc_pkg::ACC_OFS_CTRL_B, 16'h4000);
        chk("oe_n", 16'h0000, {14'h0000, mg_o, oe_n});
        wr(acc_pkg::ACC_OFS_CTRL_B, 16'h0000);
        chk("oe_n_off", 16'h0001, {15'h0000, oe_n});
        wr(4'h3, 16'hFFFF);
        rd(4'h3, 16'h0000, "unmapped");
        // host keeps divisors within 8 to 127
        wr(acc_pkg::ACC_OFS_CTRL_A, 16'h0809);
        chk("gain", 16'h0010, {11'h000, gain});
        gap(0, n);
        chk("odd_tick", 16'h0024, 16'(n));
        // cancellation goes on before the gain rises above 30 dB
        wr(acc_pkg::ACC_OFS_MODE, 16'h2000);
        chk("offcan_hi", 16'h0001, {15'h0000, ocan});
        wr(acc_pkg::ACC_OFS_CTRL_A, 16'h0F88);
        rd(acc_pkg::ACC_OFS_CTRL_A, 16'h0F88, "ctrl_a");
        chk("gain", 16'h001F, {11'h000, gain});
        gap(0, n);
        chk("even_tick", 16'h0020, 16'(n));
        gap(1, n);
        chk("frame", 16'h0800, 16'(n));
        mic = 1'b1;
        wr(acc_pkg::ACC_OFS_CTRL_B, 16'h4000);
        gap(2, n);
        chk("rec_full", 16'hF000, rec);
        chk("dac_full", 16'h000F, {12'h000, dac});
        rd(acc_pkg::ACC_OFS_STATUS, 16'hF000, "status");
        wr(acc_pkg::ACC_OFS_CTRL_B, 16'h0000);
        gap(2, n);
        chk("rec_off", 16'h0000, rec);
        // loopback with one 3 dB step: a quarter off full scale is code 12
        wr(acc_pkg::ACC_OFS_CTRL_B, 16'h1001);
        gap(2, n);
        chk("dac_att", 16'h000C, {12'h000, dac});
        chk("rec_loop", 16'hC000, rec);
        // mute in loopback: the DAC code and the recorded sample go to zero
        wr(acc_pkg::ACC_OFS_CTRL_B, 16'h3000);
        gap(2, n);
        chk("dac_mute", 16'h0000, {12'h000, dac});
        chk("rec_mute", 16'h0000, rec);
        end_sim();
    end
endmodule
bind acc_top acc_top_assertions acc_top_assertions_i (.ref_clk(ref_clk), .rst(rst),
    .serial_bus_clock(serial_bus_clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_rdata(reg_rdata), .mic_positive_input(mic_positive_input),
    .play_sample(play_sample), .play_ready(play_ready), .rec_sample(rec_sample),
    .rec_valid(rec_valid), .mod_tick(mod_tick), .dac_code(dac_code),
    .offset_cancel_enable(offset_cancel_enable), .input_gain_setting(input_gain_setting),
    .mic_ground_return_o(mic_ground_return_o),
    .mic_ground_return_oe_n(mic_ground_return_oe_n));
